// ===== hw/dtg_pkg.sv
package dtg_pkg;

    // ********************************************************
    // Register map
    // ********************************************************
    localparam logic [7:0] DIV_SEL_OFFSET = 8'h23;
    localparam logic [7:0] CHAN_B_OFFSET  = 8'h24;
    localparam logic [7:0] CHAN_A_OFFSET  = 8'h25;

    localparam logic [1:0] DIV_SEL_RESET  = 2'h0;
    localparam logic [7:0] CHAN_RESET     = 8'h00;

    // ********************************************************
    // Field layout
    // ********************************************************
    localparam int TRUE_MSB = 7;
    localparam int TRUE_LSB = 4;
    localparam int COMP_MSB = 3;
    localparam int COMP_LSB = 0;

    // ********************************************************
    // Clock source and divider select codes
    // ********************************************************
    localparam logic       SRC_SYSTEM = 1'b0;
    localparam logic       SRC_FAST   = 1'b1;
    localparam logic [1:0] DIV_BY_1   = 2'h0;
    localparam logic [1:0] DIV_BY_2   = 2'h1;
    localparam logic [1:0] DIV_BY_4   = 2'h2;
    localparam logic [1:0] DIV_BY_8   = 2'h3;

endpackage

// ===== hw/dtg_tick_if.sv
`timescale 1ns/100ps
interface dtg_tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input tick);
endinterface

// ===== hw/dtg_prescaler.sv
`timescale 1ns/100ps
module dtg_prescaler (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       timer_tick,
    input  wire logic [1:0] div_sel,
    dtg_tick_if.src         dt
);
    logic [2:0] cnt;
    logic [2:0] next_cnt;
    logic       next_tick;
    logic       hit;

    // ********************************************************
    // Divider
    // ********************************************************
    always_comb begin
        unique case (div_sel)
            dtg_pkg::DIV_BY_1: hit = 1'b1;
            dtg_pkg::DIV_BY_2: hit = cnt[0];
            dtg_pkg::DIV_BY_4: hit = &cnt[1:0];
            dtg_pkg::DIV_BY_8: hit = &cnt;
        endcase
        next_cnt  = cnt;
        next_tick = 1'b0;
        if (timer_tick) begin
            next_cnt  = hit ? 3'h0 : cnt + 3'h1;
            next_tick = hit;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt     <= 3'h0;
            dt.tick <= 1'b0;
        end else begin
            cnt     <= next_cnt;
            dt.tick <= next_tick;
        end
    end
endmodule

// ===== hw/dtg_channel.sv
`timescale 1ns/100ps
module dtg_channel (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       pwm,
    input  wire logic [7:0] delays,
    dtg_tick_if.dst         dt,
    output logic            out_true,
    output logic            out_comp
);
    logic       pwm_q;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic       next_true;
    logic       next_comp;
    logic       edge_seen;

    always_comb begin
        edge_seen = pwm ^ pwm_q;
        next_cnt  = cnt;
        next_true = out_true;
        next_comp = out_comp;
        if (edge_seen) begin
            // A rise times the true side, a fall the complement.
            // field chosen by edge
            next_cnt = pwm ? delays[dtg_pkg::TRUE_MSB:dtg_pkg::TRUE_LSB]
                           : delays[dtg_pkg::COMP_MSB:dtg_pkg::COMP_LSB];
            // Both low while the gap runs, so the switches never overlap.
            // outputs low in gap
            next_true = 1'b0;
            next_comp = 1'b0;
        end else if (cnt == 4'h0) begin
            next_true = pwm;
            next_comp = !pwm;
        end else if (dt.tick) begin
            next_cnt = cnt - 4'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pwm_q    <= 1'b0;
            cnt      <= 4'h0;
            out_true <= 1'b0;
            out_comp <= 1'b0;
        end else begin
            pwm_q    <= pwm;
            cnt      <= next_cnt;
            out_true <= next_true;
            out_comp <= next_comp;
        end
    end
endmodule

// ===== hw/dtg_top.sv
// Functional notes
// - Two inserters give non-overlapping output pairs.
// - Select 00,01,10,11 divides 1,2,4,8.
// - Divider runs from the active timer clock.
// - Four-bit down counter per inserter.
// - Either PWM edge starts a dead period.
// - Rise loads true field, fall complement.
// - Rising output held until counter zero.
// - Zero compare ends dead time insertion.
// - Delay equals field times divided period.
// - Separate delays per output, per channel.
// - Channel A register: true 7:4, comp 3:0.
// - Channel B register: true 7:4, comp 3:0.
// - Shared two-bit divider select at 0x23.
//
// Our own choice: strobed register access.
`timescale 1ns/100ps
module dtg_top (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       pwm_chan_a,
    input  wire logic       pwm_chan_b,
    input  wire logic       fast_peripheral_clock,
    input  wire logic       system_clock,
    input  wire logic       clock_source_sel,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    output logic            pwm_chan_a_out,
    output logic            pwm_chan_a_out_comp,
    output logic            pwm_chan_b_out,
    output logic            pwm_chan_b_out_comp
);
    // ********************************************************
    // Registers
    // ********************************************************
    logic [1:0] dead_time_divider_select;
    logic [7:0] dead_time_channel_a;
    logic [7:0] dead_time_channel_b;
    logic [1:0] next_div;
    logic [7:0] next_a;
    logic [7:0] next_b;
    logic [7:0] next_rdata;

    always_comb begin
        next_div   = dead_time_divider_select;
        next_a     = dead_time_channel_a;
        next_b     = dead_time_channel_b;
        next_rdata = 8'h00;
        if (reg_write) begin
            unique case (reg_addr)
                dtg_pkg::DIV_SEL_OFFSET: next_div = reg_wdata[1:0];
                dtg_pkg::CHAN_A_OFFSET:  next_a = reg_wdata;
                dtg_pkg::CHAN_B_OFFSET:  next_b = reg_wdata;
                default:                 next_div = dead_time_divider_select;
            endcase
        end
        if (reg_read) begin
            unique case (reg_addr)
                dtg_pkg::DIV_SEL_OFFSET:
                    next_rdata = {6'h00, dead_time_divider_select};
                dtg_pkg::CHAN_A_OFFSET:  next_rdata = dead_time_channel_a;
                dtg_pkg::CHAN_B_OFFSET:  next_rdata = dead_time_channel_b;
                default:                 next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dead_time_divider_select <= dtg_pkg::DIV_SEL_RESET;
            dead_time_channel_a      <= dtg_pkg::CHAN_RESET;
            dead_time_channel_b      <= dtg_pkg::CHAN_RESET;
            reg_rdata                <= 8'h00;
        end else begin
            dead_time_divider_select <= next_div;
            dead_time_channel_a      <= next_a;
            dead_time_channel_b      <= next_b;
            reg_rdata                <= next_rdata;
        end
    end

    // ********************************************************
    // Timer clock sampling
    // ********************************************************
    // The timer clocks are sampled as pins and each level must hold two samples, so they
    // must run at a quarter of clk or below; each sampled rise of the selected clock becomes one timer tick.
    logic [2:0] fast_sync;
    logic [2:0] sys_sync;
    logic       fast_lvl;
    logic       sys_lvl;
    logic       next_fast_lvl;
    logic       next_sys_lvl;
    logic       src_lvl;
    logic       src_lvl_q;
    logic       timer_tick;

    always_comb begin
        next_fast_lvl = fast_lvl;
        next_sys_lvl  = sys_lvl;
        if (fast_sync[1] == fast_sync[2]) begin
            next_fast_lvl = fast_sync[2];
        end
        if (sys_sync[1] == sys_sync[2]) begin
            next_sys_lvl = sys_sync[2];
        end
        src_lvl = (clock_source_sel == dtg_pkg::SRC_FAST) ? fast_lvl
                                                          : sys_lvl;
        timer_tick = src_lvl & ~src_lvl_q;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fast_sync <= 3'h0;
            sys_sync  <= 3'h0;
            fast_lvl  <= 1'b0;
            sys_lvl   <= 1'b0;
            src_lvl_q <= 1'b0;
        end else begin
            fast_sync <= {fast_sync[1:0], fast_peripheral_clock};
            sys_sync  <= {sys_sync[1:0], system_clock};
            fast_lvl  <= next_fast_lvl;
            sys_lvl   <= next_sys_lvl;
            src_lvl_q <= src_lvl;
        end
    end

    // ********************************************************
    // Prescaler and inserters
    // ********************************************************
    dtg_tick_if dt_tick ();

    // divide by 1, 2, 4, 8
    dtg_prescaler u_prescaler (
        .clk        (clk),
        .rst_b      (rst_b),
        .timer_tick (timer_tick),
        .div_sel    (dead_time_divider_select),
        .dt         (dt_tick)
    );

    dtg_channel u_chan_a (
        .clk      (clk),
        .rst_b    (rst_b),
        .pwm      (pwm_chan_a),
        .delays   (dead_time_channel_a),
        .dt       (dt_tick),
        .out_true (pwm_chan_a_out),
        .out_comp (pwm_chan_a_out_comp)
    );

    dtg_channel u_chan_b (
        .clk      (clk),
        .rst_b    (rst_b),
        .pwm      (pwm_chan_b),
        .delays   (dead_time_channel_b),
        .dt       (dt_tick),
        .out_true (pwm_chan_b_out),
        .out_comp (pwm_chan_b_out_comp)
    );
endmodule

// ===== verification/dtg_top_monitor.sv
`timescale 1ns/100ps
module dtg_top_monitor (
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       pwm_chan_a,
    input wire logic       pwm_chan_b,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic       pwm_chan_a_out,
    input wire logic       pwm_chan_a_out_comp,
    input wire logic       pwm_chan_b_out,
    input wire logic       pwm_chan_b_out_comp
);
    // ****************
    // Checks
    // ****************
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_a_apart: assert property (
        !(pwm_chan_a_out && pwm_chan_a_out_comp))
        else $error("Channel A pair overlaps.");
    a_b_apart: assert property (!(pwm_chan_b_out && pwm_chan_b_out_comp))
        else $error("Channel B pair overlaps.");
    a_a_blank: assert property ($changed(pwm_chan_a) |=>
        !pwm_chan_a_out && !pwm_chan_a_out_comp) else $error("A not blanked.");
    a_b_blank: assert property ($changed(pwm_chan_b) |=>
        !pwm_chan_b_out && !pwm_chan_b_out_comp) else $error("B not blanked.");
    a_a_true: assert property (pwm_chan_a_out |-> $past(pwm_chan_a))
        else $error("A true output high with PWM low.");
    a_b_comp: assert property (
        pwm_chan_b_out_comp |-> !$past(pwm_chan_b))
        else $error("B complement high with PWM high.");
    a_div_width: assert property (reg_read &&
        reg_addr == dtg_pkg::DIV_SEL_OFFSET |=> reg_rdata[7:2] == 6'h00)
        else $error("Divider select upper bits not zero.");
    a_chan_a_rw: assert property (reg_write &&
        reg_addr == dtg_pkg::CHAN_A_OFFSET ##1 !reg_write ##1 reg_read &&
        reg_addr == dtg_pkg::CHAN_A_OFFSET |=> reg_rdata == $past(reg_wdata, 3))
        else $error("Channel A register readback wrong.");
    c_a_rise: cover property ($rose(pwm_chan_a_out));
    c_b_comp: cover property ($rose(pwm_chan_b_out_comp));
    c_read: cover property (reg_read ##1 reg_rdata != 8'h00);
endmodule

bind dtg_top dtg_top_monitor u_mon (.clk, .rst_b, .pwm_chan_a, .pwm_chan_b,
    .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .pwm_chan_a_out, .pwm_chan_a_out_comp, .pwm_chan_b_out,
    .pwm_chan_b_out_comp);

// ===== verification/dtg_switch_model.sv
`timescale 1ns/100ps
module dtg_switch_model (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic hi_a,
    input  wire logic lo_a,
    input  wire logic hi_b,
    input  wire logic lo_b,
    output logic      shoot
);
    // The fault latches so that one overlapping cycle is never lost.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            shoot <= 1'b0;
        else if ((hi_a && lo_a) || (hi_b && lo_b))
            shoot <= 1'b1;
    end
endmodule

// ===== verification/test_pwm_dead_time_inserter.sv
`timescale 1ns/100ps
module test_pwm_dead_time_inserter;
    logic       clk = 0, rst_b = 0, pa = 0, pb = 0, fast = 0, slow = 0;
    logic       src = 1, wr = 0, rd = 0, oa, oac, ob, obc, shoot;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    int         n_mismatch = 0, compares = 0, fcnt = 0, scnt = 0;
    always #25 clk = !clk;
    // Timer clocks stay well below a quarter of clk, as the sampler needs.
    always @(posedge clk) begin
        fcnt <= (fcnt == 2) ? 0 : fcnt + 1;
        scnt <= (scnt == 4) ? 0 : scnt + 1;
        if (fcnt == 2) fast <= !fast;
        if (scnt == 4) slow <= !slow;
    end
    dtg_top dut (.clk(clk), .rst_b(rst_b), .pwm_chan_a(pa), .pwm_chan_b(pb),
        .fast_peripheral_clock(fast), .system_clock(slow),
        .clock_source_sel(src), .reg_addr(addr), .reg_wdata(wdata),
        .reg_write(wr), .reg_read(rd), .reg_rdata(rdata),
        .pwm_chan_a_out(oa), .pwm_chan_a_out_comp(oac),
        .pwm_chan_b_out(ob), .pwm_chan_b_out_comp(obc));
    dtg_switch_model u_sw (.clk(clk), .rst_b(rst_b), .hi_a(oa), .lo_a(oac),
        .hi_b(ob), .lo_b(obc), .shoot(shoot));
    // ****************
    // Tasks
    // ****************
    task check(input string what, input logic [7:0] seen, input logic [7:0] e);
        compares++;
        if (seen !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %0h seen %0h", what, e, seen);
        end
    endtask
    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk); wr <= 1; addr <= a; wdata <= d;
        @(posedge clk); wr <= 0;
    endtask
    task rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk); rd <= 1; addr <= a;
        @(posedge clk); rd <= 0;
        #1 check("rdata", rdata, e);
    endtask
    // The prescaler phase is free, so the delay is judged within one tick.
    task edge_dt(input logic ch, input logic lvl, input int f, input int dp);
        int n, lo, hi;
        n = 0;
        // A zero field gives one blank cycle, so the output is back at n = 2.
        lo = (f > 0) ? (f - 1) * dp + 3 : 2;
        hi = f * dp + 6;
        @(posedge clk); if (ch) pb <= lvl; else pa <= lvl;
        do begin @(posedge clk); #1 n++; end
        while ((ch ? (lvl ? ob : obc) : (lvl ? oa : oac)) !== 1'b1 && n < 2000);
        check("dead time", {7'h00, n >= lo && n <= hi}, 8'h01);
    endtask
    task run(input logic ch, input logic s, input logic [1:0] ds,
             input logic [3:0] ft, input logic [3:0] fc);
        int dp;
        dp = (s ? 6 : 10) << ds;
        @(posedge clk); src <= s;
        wr_reg(dtg_pkg::DIV_SEL_OFFSET, {6'h00, ds});
        wr_reg(ch ? dtg_pkg::CHAN_B_OFFSET : dtg_pkg::CHAN_A_OFFSET, {ft, fc});
        edge_dt(ch, 1'b1, ft, dp);
        edge_dt(ch, 1'b0, fc, dp);
    endtask
    task stop_test;
        if (n_mismatch == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ****************
    // Sequence
    // ****************
    initial begin
        #1000000 n_mismatch++;
        stop_test;
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1;
        rd_chk(dtg_pkg::DIV_SEL_OFFSET, 8'h00);
        rd_chk(dtg_pkg::CHAN_B_OFFSET, 8'h00);
        rd_chk(dtg_pkg::CHAN_A_OFFSET, 8'h00);
        wr_reg(dtg_pkg::DIV_SEL_OFFSET, 8'hFF);
        rd_chk(dtg_pkg::DIV_SEL_OFFSET, 8'h03);
        wr_reg(dtg_pkg::CHAN_B_OFFSET, 8'hA5);
        rd_chk(dtg_pkg::CHAN_B_OFFSET, 8'hA5);
        wr_reg(dtg_pkg::CHAN_A_OFFSET, 8'h5A);
        rd_chk(dtg_pkg::CHAN_A_OFFSET, 8'h5A);
        wr_reg(8'h26, 8'h77);
        rd_chk(8'h26, 8'h00);
        for (int i = 0; i < 4; i++) run(0, 1, i[1:0], 4'h3, 4'h2);
        run(0, 0, 2'h0, 4'h0, 4'h7);
        run(1, 0, 2'h3, 4'hF, 4'h1);
        run(1, 1, 2'h1, 4'h1, 4'hF);
        check("overlap", {7'h00, shoot}, 8'h00);
        stop_test;
    end
endmodule
